// ==== scs_pkg.sv ====
/*
 * Shared constants and types for the system calibration sequencer: mode codes,
 * gain table, coefficient reset values and the timing counts of both ends.
 * Assumes a 20 MHz system clock and a converter whose output rate and master
 * clock are fixed at build time.
 */
package scs_pkg;

	// Converter word widths.
	localparam int unsigned SAMPLE_W = 24;
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned GAINED_W = 31;  // SAMPLE_W plus the largest gain shift.

	// Clock rates.
	localparam longint unsigned SYS_CLK_HZ = 20_000_000;
	localparam longint unsigned MCLK_HZ    = 2_457_600;
	localparam longint unsigned OUT_RATE_HZ = 50;

	// One output-rate period, in ns and in system clocks.
	localparam longint unsigned OUT_PERIOD_NS   = 64'd1_000_000_000 / OUT_RATE_HZ;
	localparam int unsigned     OUT_PERIOD_CLKS =
		int'((OUT_PERIOD_NS * SYS_CLK_HZ) / 64'd1_000_000_000);

	// Calibration step length and command-to-ready time, in output periods.
	localparam logic [2:0] CAL_STEP_PERIODS  = 3'h3;
	localparam logic [2:0] CAL_READY_PERIODS = 3'h4;

	// One modulator cycle of 128 master clocks; least time, rounded up.
	localparam longint unsigned MOD_CYCLE_MCLKS = 128;
	localparam longint unsigned MOD_CYCLE_NS    =
		(MOD_CYCLE_MCLKS * 64'd1_000_000_000 + MCLK_HZ - 1) / MCLK_HZ;
	localparam int unsigned     MOD_IGNORE_CLKS =
		int'((MOD_CYCLE_NS * SYS_CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

	// Oscillator start-up wait before any calibration, least time.
	localparam longint unsigned OSC_START_MS   = 16;
	localparam int unsigned     OSC_START_CLKS = int'((OSC_START_MS * SYS_CLK_HZ) / 64'd1000);

	// Calibration mode field codes (high bit, low bit).
	typedef enum logic [1:0] {
		SCS_MODE_NORMAL = 2'h0,
		SCS_MODE_SELF   = 2'h1,
		SCS_MODE_ZS     = 2'h2,
		SCS_MODE_FS     = 2'h3
	} scs_mode_t;

	// Gain code to left shift: gains 1, 2, 64 and 128, three bits per code.
	localparam logic [11:0] GAIN_SHIFT_TABLE = 12'hf88;

	// Nominal coefficients loaded at reset.
	localparam logic [SAMPLE_W-1:0] ZS_RESET   = 24'h000000;
	localparam logic [SAMPLE_W-1:0] SPAN_RESET = 24'h400000;

	// Output word landmarks.
	localparam logic [WORD_W-1:0] WORD_MIDSCALE = 16'h8000;
	localparam logic [WORD_W-1:0] WORD_FULL     = 16'hffff;

endpackage : scs_pkg

// ==== scs_if.sv ====
/*
 * Link between the host controller and the converter's calibration logic.
 * Assumes both ends share sys_clk; command fields are valid while cmd_valid.
 */
`timescale 1ns/1ps
`default_nettype none
interface scs_if;
	logic                         cmd_valid;
	logic [1:0]                   cmd_mode;
	logic                         gain_select_hi;
	logic                         gain_select_lo;
	logic                         bipolar;
	logic [1:0]                   mode_live;
	logic                         result_ready_n;
	logic                         data_rd;
	logic [scs_pkg::WORD_W-1:0]   data_word;

	modport dev  (input cmd_valid, cmd_mode, gain_select_hi, gain_select_lo, bipolar, data_rd,
	              output mode_live, result_ready_n, data_word);
	modport host (output cmd_valid, cmd_mode, gain_select_hi, gain_select_lo, bipolar, data_rd,
	              input mode_live, result_ready_n, data_word);
endinterface : scs_if
`default_nettype wire

// ==== scs_device.sv ====
/*
 * Converter-side calibration sequencer: runs zero-scale and full-scale system
 * calibration steps, keeps the coefficients, produces conversion words and
 * drives the active-low result-ready line.
 * Assumes the analog input arrives as a signed digital sample synchronous to
 * sys_clk and that the host keeps its side of the calibration sequence.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_device #(
	parameter int unsigned PERIOD_CLKS = scs_pkg::OUT_PERIOD_CLKS
) (
	input  wire logic                                sys_clk,
	input  wire logic                                reset_n,
	input  wire logic                                clk_en,
	scs_if.dev                                       link,
	input  wire logic signed [scs_pkg::SAMPLE_W-1:0] analog_input_pair,
	output logic             [scs_pkg::SAMPLE_W-1:0] zero_scale,
	output logic             [scs_pkg::SAMPLE_W-1:0] full_scale,
	output logic                                     cal_busy
);

	localparam int unsigned GW = scs_pkg::GAINED_W;
	localparam int unsigned NW = GW + 18;

	typedef enum logic [1:0] {
		SCS_DEV_IDLE   = 2'h0,
		SCS_DEV_CAL    = 2'h1,
		SCS_DEV_SETTLE = 2'h2
	} scs_dev_state_t;

	scs_dev_state_t                   state_reg, state_next;
	logic [1:0]                       mode_reg, mode_next;
	logic [31:0]                      clk_cnt_reg, clk_cnt_next;
	logic [2:0]                       step_cnt_reg, step_cnt_next;
	logic [1:0]                       gain_reg, gain_next;
	logic                             bip_reg, bip_next;
	logic [scs_pkg::SAMPLE_W-1:0]     zs_reg, zs_next;
	logic [scs_pkg::SAMPLE_W-1:0]     span_reg, span_next;
	logic [scs_pkg::WORD_W-1:0]       word_reg, word_next;
	logic                             ready_n_reg, ready_n_next;

	logic                             period_end;
	logic [2:0]                       gain_shift;
	logic signed [GW-1:0]             gained;
	logic signed [GW:0]               diff;
	logic signed [GW:0]               span_cand;
	logic signed [NW-1:0]             num;
	logic signed [NW-1:0]             quo;
	logic [scs_pkg::WORD_W-1:0]       conv_word;

	// The conversion path always uses the gain latched at the last setup write,
	// so a calibration step and the words after it see the same front-end gain.
	always_comb begin
		gain_shift = scs_pkg::GAIN_SHIFT_TABLE[{gain_reg, 2'b00} - {2'b00, gain_reg} +: 3];
		gained     = GW'(analog_input_pair) <<< gain_shift;
		diff       = GW'(gained) - $signed({{(GW + 1 - scs_pkg::SAMPLE_W){zs_reg[scs_pkg::SAMPLE_W-1]}},
		                                    zs_reg});
		span_cand  = diff;
		// Bipolar halves the scale so that zero difference lands on midscale.
		if (bip_reg) begin
			num = NW'(diff) <<< 15;
		end else begin
			num = NW'(diff) <<< 16;
		end
		quo = num / $signed({{(NW - scs_pkg::SAMPLE_W){1'b0}}, span_reg});
		if (bip_reg) begin
			quo = quo + NW'(32768);
		end
		// Clip rather than wrap; out-of-range inputs pin to the rails.
		if (quo < 0) begin
			conv_word = '0;
		end else if (quo > NW'(65535)) begin
			conv_word = scs_pkg::WORD_FULL;
		end else begin
			conv_word = quo[scs_pkg::WORD_W-1:0];
		end
	end

	// Sequencer next state: output-period timing, steps, coefficients, word and ready.
	always_comb begin
		state_next    = state_reg;
		mode_next     = mode_reg;
		step_cnt_next = step_cnt_reg;
		gain_next     = gain_reg;
		bip_next      = bip_reg;
		zs_next       = zs_reg;
		span_next     = span_reg;
		word_next     = word_reg;
		ready_n_next  = ready_n_reg;
		period_end    = (clk_cnt_reg == PERIOD_CLKS - 1);
		clk_cnt_next  = period_end ? 32'h0 : clk_cnt_reg + 32'h1;

		// Reading the word hands it over; the line stays high until the next one.
		if (link.data_rd) begin
			ready_n_next = 1'b1;
		end

		case (state_reg)
			SCS_DEV_IDLE: begin
				if (period_end) begin
					word_next    = conv_word;
					ready_n_next = 1'b0;
				end
			end
			SCS_DEV_CAL: begin
				if (period_end) begin
					if (step_cnt_reg == scs_pkg::CAL_STEP_PERIODS - 3'h1) begin
						// Each step touches only its own coefficient.
						if (mode_reg == scs_pkg::SCS_MODE_ZS) begin
							zs_next = gained[scs_pkg::SAMPLE_W-1:0];
						end else if (span_cand > 0) begin
							span_next = span_cand[scs_pkg::SAMPLE_W-1:0];
						end
						mode_next  = scs_pkg::SCS_MODE_NORMAL;
						state_next = SCS_DEV_SETTLE;
					end else begin
						step_cnt_next = step_cnt_reg + 3'h1;
					end
				end
			end
			SCS_DEV_SETTLE: begin
				// One normal conversion after the step: word on the fourth period end.
				if (period_end) begin
					word_next    = conv_word;
					ready_n_next = 1'b0;
					state_next   = SCS_DEV_IDLE;
				end
			end
			default: begin
				state_next = SCS_DEV_IDLE;
			end
		endcase

		// A setup write always refreshes gain and polarity; a system mode code
		// restarts the filter and begins a step from wherever we were.
		if (link.cmd_valid) begin
			gain_next = {link.gain_select_hi, link.gain_select_lo};
			bip_next  = link.bipolar;
			if (link.cmd_mode[1]) begin
				mode_next     = link.cmd_mode;
				state_next    = SCS_DEV_CAL;
				step_cnt_next = 3'h0;
				clk_cnt_next  = 32'h0;
				// Raised on the very next edge, well inside one modulator cycle.
				ready_n_next  = 1'b1;
			end
		end
	end

	// State registers; clk_en low freezes everything.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg    <= SCS_DEV_IDLE;
			mode_reg     <= scs_pkg::SCS_MODE_NORMAL;
			clk_cnt_reg  <= 32'h0;
			step_cnt_reg <= 3'h0;
			gain_reg     <= 2'h0;
			bip_reg      <= 1'b0;
			zs_reg       <= scs_pkg::ZS_RESET;
			span_reg     <= scs_pkg::SPAN_RESET;
			word_reg     <= '0;
			ready_n_reg  <= 1'b1;
		end else if (clk_en) begin
			state_reg    <= state_next;
			mode_reg     <= mode_next;
			clk_cnt_reg  <= clk_cnt_next;
			step_cnt_reg <= step_cnt_next;
			gain_reg     <= gain_next;
			bip_reg      <= bip_next;
			zs_reg       <= zs_next;
			span_reg     <= span_next;
			word_reg     <= word_next;
			ready_n_reg  <= ready_n_next;
		end
	end

	// Outputs other than cal_busy come straight from registers.
	assign link.mode_live      = mode_reg;
	assign link.result_ready_n = ready_n_reg;
	assign link.data_word      = word_reg;
	assign zero_scale          = zs_reg;
	assign full_scale          = span_reg;
	assign cal_busy            = (state_reg != SCS_DEV_IDLE);

endmodule : scs_device
`default_nettype wire

// ==== scs_host.sv ====
/*
 * Host-side calibration controller: waits for the oscillator, asks the user
 * logic to apply each input condition, issues the step commands, ignores the
 * ready line for one modulator cycle, polls for completion and reads words.
 * Assumes the user logic reports cond_ready only once the input is stable.
 */
`timescale 1ns/1ps
`default_nettype none
module scs_host #(
	parameter int unsigned OSC_WAIT_CLKS = scs_pkg::OSC_START_CLKS,
	parameter bit          AUTO_CAL      = 1'b1
) (
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	input  wire logic                        clk_en,
	scs_if.host                              link,
	input  wire logic                        cal_start,
	input  wire logic [1:0]                  cal_kind,
	input  wire logic [1:0]                  gain_sel,
	input  wire logic                        bipolar_sel,
	input  wire logic                        cond_ready,
	output logic                             apply_zero,
	output logic                             apply_full,
	output logic                             busy,
	output logic                             cal_done,
	output logic                             result_valid,
	output logic [scs_pkg::WORD_W-1:0]       result_word
);

	typedef enum logic [2:0] {
		SCS_H_BOOT  = 3'h0,
		SCS_H_IDLE  = 3'h1,
		SCS_H_REQ   = 3'h2,
		SCS_H_WRITE = 3'h3,
		SCS_H_BLIND = 3'h4,
		SCS_H_POLL  = 3'h5,
		SCS_H_WAIT  = 3'h6
	} scs_host_state_t;

	scs_host_state_t              state_reg, state_next;
	logic [31:0]                  cnt_reg, cnt_next;
	logic [1:0]                   kind_reg, kind_next;
	logic [1:0]                   step_reg, step_next;
	logic [1:0]                   gain_reg, gain_next;
	logic                         bip_reg, bip_next;
	logic                         auto_reg, auto_next;
	logic [scs_pkg::WORD_W-1:0]   word_reg, word_next;
	logic                         valid_reg, valid_next;
	logic                         done_reg, done_next;
	logic                         rd;

	// cal_kind: SCS_MODE_NORMAL means full two-step run, ZS or FS a single step.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		kind_next  = kind_reg;
		step_next  = step_reg;
		gain_next  = gain_reg;
		bip_next   = bip_reg;
		auto_next  = auto_reg;
		word_next  = word_reg;
		valid_next = 1'b0;
		done_next  = 1'b0;
		rd         = 1'b0;
		case (state_reg)
			SCS_H_BOOT: begin
				cnt_next = cnt_reg + 32'h1;
				if (cnt_reg >= OSC_WAIT_CLKS - 1) begin
					state_next = SCS_H_IDLE;
				end
			end
			SCS_H_IDLE: begin
				if (cal_start || auto_reg) begin
					kind_next  = auto_reg ? scs_pkg::SCS_MODE_NORMAL : cal_kind;
					step_next  = (!auto_reg && cal_kind == scs_pkg::SCS_MODE_FS) ?
					             scs_pkg::SCS_MODE_FS : scs_pkg::SCS_MODE_ZS;
					gain_next  = gain_sel;
					bip_next   = bipolar_sel;
					auto_next  = 1'b0;
					state_next = SCS_H_REQ;
				end else if (!link.result_ready_n) begin
					rd         = 1'b1;
					word_next  = link.data_word;
					valid_next = 1'b1;
				end
			end
			SCS_H_REQ: begin
				if (cond_ready) begin
					state_next = SCS_H_WRITE;
				end
			end
			SCS_H_WRITE: begin
				cnt_next   = 32'h0;
				state_next = SCS_H_BLIND;
			end
			SCS_H_BLIND: begin
				// The ready line was raised by the command; it may go low here with the settle word of the held level.
				cnt_next = cnt_reg + 32'h1;
				if (cnt_reg >= scs_pkg::MOD_IGNORE_CLKS - 1) begin
					state_next = SCS_H_POLL;
				end
			end
			SCS_H_POLL: begin
				if (link.mode_live == scs_pkg::SCS_MODE_NORMAL) begin
					if (kind_reg == scs_pkg::SCS_MODE_NORMAL && step_reg == scs_pkg::SCS_MODE_ZS) begin
						step_next  = scs_pkg::SCS_MODE_FS;
						state_next = SCS_H_REQ;
					end else begin
						state_next = SCS_H_WAIT;
					end
				end
			end
			SCS_H_WAIT: begin
				if (!link.result_ready_n) begin
					rd         = 1'b1;
					word_next  = link.data_word;
					valid_next = 1'b1;
					done_next  = 1'b1;
					state_next = SCS_H_IDLE;
				end
			end
			default: begin
				state_next = SCS_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg <= SCS_H_BOOT;
			cnt_reg   <= 32'h0;
			kind_reg  <= scs_pkg::SCS_MODE_NORMAL;
			step_reg  <= scs_pkg::SCS_MODE_ZS;
			gain_reg  <= 2'h0;
			bip_reg   <= 1'b0;
			auto_reg  <= AUTO_CAL;
			word_reg  <= '0;
			valid_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			kind_reg  <= kind_next;
			step_reg  <= step_next;
			gain_reg  <= gain_next;
			bip_reg   <= bip_next;
			auto_reg  <= auto_next;
			word_reg  <= word_next;
			valid_reg <= valid_next;
			done_reg  <= done_next;
		end
	end

	// Input condition requests stay up from request until the poll sees the step complete.
	assign apply_zero = (state_reg inside {SCS_H_REQ, SCS_H_WRITE, SCS_H_BLIND, SCS_H_POLL}) &&
	                    step_reg == scs_pkg::SCS_MODE_ZS;
	assign apply_full = (state_reg inside {SCS_H_REQ, SCS_H_WRITE, SCS_H_BLIND, SCS_H_POLL}) &&
	                    step_reg == scs_pkg::SCS_MODE_FS;
	assign link.cmd_valid      = (state_reg == SCS_H_WRITE) && clk_en;
	assign link.cmd_mode       = step_reg;
	assign link.gain_select_hi = gain_reg[1];
	assign link.gain_select_lo = gain_reg[0];
	assign link.bipolar        = bip_reg;
	assign link.data_rd        = rd && clk_en;
	assign busy                = (state_reg != SCS_H_IDLE);
	assign cal_done            = done_reg;
	assign result_valid        = valid_reg;
	assign result_word         = word_reg;

endmodule : scs_host
`default_nettype wire

// ==== scs_sva.sv ====
/*
 * Checker for the calibration link between host and device ends.
 * Assumes it is instantiated beside the link, on sys_clk with synchronous reset_n.
 */
`timescale 1ns/1ps
`default_nettype none
module scs_sva #(
	parameter int PERIOD_CLKS = 20
) (
	input wire logic                       sys_clk,
	input wire logic                       reset_n,
	input wire logic                       cmd_valid,
	input wire logic [1:0]                 cmd_mode,
	input wire logic [1:0]                 mode_live,
	input wire logic                       result_ready_n,
	input wire logic                       data_rd,
	input wire logic [scs_pkg::WORD_W-1:0] data_word
);
	localparam int STEP_C  = 3 * PERIOD_CLKS;
	localparam int READY_C = 4 * PERIOD_CLKS;
	logic        start;
	logic [10:0] since_reg;
	logic [10:0] since_next;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Cycles since the last step command; saturates so long idle spells stay quiet.
	assign start = cmd_valid && cmd_mode[1];
	always_comb begin
		since_next = since_reg;
		if (start) begin
			since_next = 11'h001;
		end else if (since_reg != 11'h000 && since_reg != 11'h7ff) begin
			since_next = since_reg + 11'h001;
		end
	end
	always_ff @(posedge sys_clk) begin
		since_reg <= reset_n ? since_next : 11'h000;
	end

	AST_ZS_START: assert property (start && cmd_mode == 2'h2 |=> mode_live == 2'h2 && result_ready_n)
		else $error("zero-scale command not taken");
	AST_FS_START: assert property (start && cmd_mode == 2'h3 |=> mode_live == 2'h3 && result_ready_n)
		else $error("full-scale command not taken");
	AST_STEP_RUNS: assert property (since_reg >= 1 && since_reg < STEP_C && !start |-> mode_live != 2'h0)
		else $error("mode field cleared early");
	AST_STEP_ENDS: assert property (since_reg > STEP_C && since_reg <= READY_C + 1 && !start |-> mode_live == 2'h0)
		else $error("mode field not cleared after step");
	AST_READY_HELD: assert property (since_reg >= 1 && since_reg < READY_C && !start |-> result_ready_n)
		else $error("ready line low during step");
	AST_READY_DROPS: assert property (since_reg == READY_C + 1 |-> !result_ready_n)
		else $error("ready line not low after settle conversion");
	AST_HOST_BLIND: assert property (since_reg >= 1 && since_reg <= scs_pkg::MOD_IGNORE_CLKS |-> !data_rd)
		else $error("host read inside the ignore window");
	AST_READ_CLEARS: assert property (data_rd && !result_ready_n |=> result_ready_n || $changed(data_word))
		else $error("read did not release ready line");
	AST_LIVE_SOURCE: assert property ($changed(mode_live) && mode_live != 2'h0 |-> $past(start) && mode_live == $past(cmd_mode))
		else $error("mode field changed without a command");
	AST_RESET_DEFAULTS: assert property ($rose(reset_n) |-> mode_live == 2'h0 && result_ready_n)
		else $error("link outputs not at defaults after reset");

	CV_ZS: cover property (start && cmd_mode == 2'h2);
	CV_FS: cover property (start && cmd_mode == 2'h3);
	CV_READ: cover property (data_rd && !result_ready_n);
endmodule : scs_sva
`default_nettype wire

// ==== testbench.sv ====
/*
 * Self-checking bench: host and device ends joined by the link, checker beside it.
 * Assumes the package, link, both ends and scs_sva.sv are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                                sys_clk;
	logic                                reset_n;
	logic                                clk_en;
	logic                                cal_start;
	logic                                cond_ready;
	logic                                bipolar_sel;
	logic                                cal_busy, apply_zero, apply_full, busy, cal_done, result_valid;
	logic [1:0]                          cal_kind, gain_sel;
	logic signed [scs_pkg::SAMPLE_W-1:0] analog_input_pair, zs_raw, fs_raw, idle_raw;
	logic [scs_pkg::SAMPLE_W-1:0]        zero_scale, full_scale;
	logic [scs_pkg::WORD_W-1:0]          result_word, last_word;
	int                                  err_count, n_tests, cyc, sh;

	scs_if link_if();
	scs_device #(.PERIOD_CLKS(20)) scs_device_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.clk_en(clk_en), .link(link_if), .analog_input_pair(analog_input_pair),
		.zero_scale(zero_scale), .full_scale(full_scale), .cal_busy(cal_busy));
	scs_host #(.OSC_WAIT_CLKS(10), .AUTO_CAL(1'b0)) scs_host_i (.sys_clk(sys_clk),
		.reset_n(reset_n), .clk_en(clk_en), .link(link_if), .cal_start(cal_start),
		.cal_kind(cal_kind), .gain_sel(gain_sel), .bipolar_sel(bipolar_sel),
		.cond_ready(cond_ready), .apply_zero(apply_zero), .apply_full(apply_full),
		.busy(busy), .cal_done(cal_done), .result_valid(result_valid),
		.result_word(result_word));
	scs_sva #(.PERIOD_CLKS(20)) scs_sva_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.cmd_valid(link_if.cmd_valid), .cmd_mode(link_if.cmd_mode),
		.mode_live(link_if.mode_live), .result_ready_n(link_if.result_ready_n),
		.data_rd(link_if.data_rd), .data_word(link_if.data_word));

	// A 50 ns clock, matching the 20 MHz system rate.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Stand-in for the analog front: the requested level is set, reported stable only
	// once it is really on the input, then held until the request drops. A ready left
	// over from the zero-scale level still answers the first cycle of a full-scale request.
	always @(posedge sys_clk) begin
		analog_input_pair <= apply_zero ? zs_raw : (apply_full ? fs_raw : idle_raw);
		cond_ready <= (apply_zero && analog_input_pair == zs_raw) ||
		              (apply_full && analog_input_pair == fs_raw);
	end

	// Keep the last word the host delivered; it is a one-cycle pulse.
	always @(posedge sys_clk) begin
		if (result_valid === 1'b1) last_word <= result_word;
	end

	// Hang guard: the whole run needs about 14000 cycles.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			$display("BAD run_length expected finish seen hang");
			final_report();
		end
	end

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic int gshift(input logic [1:0] g);
		case (g)
			2'h0: return 0;
			2'h1: return 1;
			2'h2: return 6;
			default: return 7;
		endcase
	endfunction : gshift

	// One host calibration job; waits a bounded time for completion.
	task automatic run_cal(input logic [1:0] kind, input logic [1:0] g, input logic bip);
		int n;
		@(posedge sys_clk);
		cal_kind <= kind;
		gain_sel <= g;
		bipolar_sel <= bip;
		cal_start <= 1'b1;
		@(posedge sys_clk);
		cal_start <= 1'b0;
		@(negedge sys_clk);
		check("apply_zero", {23'h0, kind != 2'h3}, {23'h0, apply_zero});
		check("apply_full", {23'h0, kind == 2'h3}, {23'h0, apply_full});
		n = 0;
		while (cal_done !== 1'b1 && n < 6000) begin
			@(negedge sys_clk);
			n++;
		end
		check("cal_done", 24'h000001, {23'h0, cal_done});
		repeat (2) @(negedge sys_clk);
		check("mode_live", 24'h000000, {22'h0, link_if.mode_live});
		check("cal_busy", 24'h000000, {23'h0, cal_busy});
		check("busy", 24'h000000, {23'h0, busy});
		// The word handed over with cal_done still converts the held calibration level;
		// wait until a word of the idle level has been read.
		repeat (45) @(negedge sys_clk);
	endtask : run_cal

	task automatic t_defaults();
		@(negedge sys_clk);
		check("zero_scale", scs_pkg::ZS_RESET, zero_scale);
		check("full_scale", scs_pkg::SPAN_RESET, full_scale);
		check("ready_n", 24'h000001, {23'h0, link_if.result_ready_n});
		$display("test defaults done");
	endtask : t_defaults

	// Full two-step job at every gain code; points stay inside the span limits.
	task automatic t_unipolar();
		for (int g = 0; g < 4; g++) begin
			zs_raw = 24'h000100;
			fs_raw = 24'h004100;
			idle_raw = 24'h002100;
			sh = gshift(g[1:0]);
			run_cal(2'h0, g[1:0], 1'b0);
			check("zero_scale", 24'(zs_raw <<< sh), zero_scale);
			check("full_scale", 24'((fs_raw - zs_raw) <<< sh), full_scale);
			check("word", {8'h00, scs_pkg::WORD_MIDSCALE}, {8'h00, last_word});
		end
		$display("test unipolar done");
	endtask : t_unipolar

	task automatic t_bipolar();
		idle_raw = zs_raw;
		run_cal(2'h0, 2'h1, 1'b1);
		check("word", {8'h00, scs_pkg::WORD_MIDSCALE}, {8'h00, last_word});
		idle_raw = fs_raw;
		run_cal(2'h3, 2'h1, 1'b1);
		check("word", {8'h00, scs_pkg::WORD_FULL}, {8'h00, last_word});
		check("full_scale", 24'h008000, full_scale);
		$display("test bipolar done");
	endtask : t_bipolar

	task automatic t_repeat();
		zs_raw = 24'h000300;
		idle_raw = 24'h002300;
		run_cal(2'h2, 2'h1, 1'b0);
		check("zero_scale", 24'h000600, zero_scale);
		check("full_scale", 24'h008000, full_scale);
		fs_raw = 24'h005300;
		run_cal(2'h3, 2'h1, 1'b0);
		check("zero_scale", 24'h000600, zero_scale);
		check("full_scale", 24'h00a000, full_scale);
		$display("test repeat done");
	endtask : t_repeat

	// Freeze both ends while the input moves, then let them run on.
	task automatic t_freeze();
		logic [scs_pkg::WORD_W-1:0] snap_word;
		logic                       snap_rdy;
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(negedge sys_clk);
		snap_word = link_if.data_word;
		snap_rdy = link_if.result_ready_n;
		idle_raw = 24'h002b00;
		repeat (50) @(negedge sys_clk);
		check("frozen_word", {8'h00, snap_word}, {8'h00, link_if.data_word});
		check("frozen_rdy", {23'h0, snap_rdy}, {23'h0, link_if.result_ready_n});
		@(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (45) @(negedge sys_clk);
		check("word", {8'h00, scs_pkg::WORD_MIDSCALE}, {8'h00, last_word});
		$display("test freeze done");
	endtask : t_freeze

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// Main sequence: reset, oscillator wait, then calibrate.
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		cal_start = 1'b0;
		cal_kind = 2'h0;
		gain_sel = 2'h0;
		bipolar_sel = 1'b0;
		zs_raw = 24'h0;
		fs_raw = 24'h0;
		idle_raw = 24'h0;
		err_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_defaults();
		repeat (20) @(posedge sys_clk);
		t_unipolar();
		zs_raw = 24'h000100;
		fs_raw = 24'h004100;
		t_bipolar();
		t_repeat();
		t_freeze();
		final_report();
	end
endmodule : testbench
`default_nettype wire
